// ===== rtl/eawc_pkg.sv
package eawc_pkg;

  // ****************************************************************
  // Register map.
  // ****************************************************************
  localparam logic [7:0]  OFS_WAIT_CTRL  = 8'h00;
  localparam logic [7:0]  OFS_IF_CFG     = 8'h04;
  localparam logic [7:0]  OFS_STATUS     = 8'h08;
  localparam int          AREA3_LSB      = 13;
  localparam int          AREA2_LSB      = 9;
  localparam int          AREA1_LSB      = 6;
  localparam int          AREA0_LSB      = 3;
  localparam int          BURST_LSB      = 0;
  localparam logic [31:0] WAIT_CTRL_RST  = 32'h0000_EFFF;
  localparam logic [31:0] WAIT_CTRL_MASK = 32'h0000_EFFF;
  localparam int          A2_TYPE_LSB    = 0;
  localparam int          A3_TYPE_LSB    = 2;
  localparam int          MPX_BIT        = 4;
  localparam int          BROM_BIT       = 5;
  localparam int          RASD_BIT       = 6;
  localparam logic [31:0] IF_CFG_RST     = 32'h0000_0000;
  localparam logic [31:0] IF_CFG_MASK    = 32'h0000_007F;
  localparam int          ST_BUSY_BIT    = 0;
  localparam int          ST_ILLEGAL_BIT = 1;
  localparam int          ST_CNT_LSB     = 4;

  // ****************************************************************
  // Types.
  // ****************************************************************
  typedef enum logic [1:0] {
    EAWC_IF_SRAM,
    EAWC_IF_DRAM,
    EAWC_IF_SDRAM,
    EAWC_IF_RSVD
  } eawc_iface_e;

  // One access request from the bus core.
  typedef struct packed {
    logic [1:0] area;
    logic       write;
    logic [2:0] beats;
  } eawc_req_s;

  // Timing decoded for one access.
  typedef struct packed {
    logic [3:0] first_wait;
    logic [3:0] later_wait;
    logic       rdy_first;
    logic       rdy_later;
    logic       cas_mode;
    logic       lat_illegal;
  } eawc_timing_s;

  // Eight-step wait table for the area fields in static and DRAM timing; the burst pitch is used raw.
  function automatic logic [3:0] wait_steps(input logic [2:0] code);
    case (code)
      3'h4:    wait_steps = 4'h6;
      3'h5:    wait_steps = 4'h9;
      3'h6:    wait_steps = 4'hC;
      3'h7:    wait_steps = 4'hF;
      default: wait_steps = {1'b0, code};
    endcase
  endfunction

endpackage

// ===== rtl/eawc_decode.sv
module eawc_decode (
  input  wire logic [2:0]           code,
  input  wire logic [2:0]           pitch,
  input  wire logic [1:0]           iface,
  input  wire logic                 multiplexed_bus_interface,
  input  wire logic                 brom_area0,
  input  wire logic                 is_write,
  input  wire logic                 ras_down,
  output eawc_pkg::eawc_timing_s    timing
);

  // Decode one area's code into waits, strobe mode and ready use.
  always_comb begin
    timing = '0;
    if (multiplexed_bus_interface) begin
      // First-beat reads never drop below one wait, writes may run with none.
      timing.first_wait = (is_write || code[1:0] != 2'h0) ?
                          {2'h0, code[1:0]} : 4'h1;
      timing.later_wait = {3'h0, code[2]};
      timing.rdy_first  = 1'b1;
      timing.rdy_later  = 1'b1;
    end else begin
      case (eawc_pkg::eawc_iface_e'(iface))
        eawc_pkg::EAWC_IF_DRAM: begin
          // Counter holds width minus one, so the strobe spans the table.
          timing.first_wait = eawc_pkg::wait_steps(code);
          timing.cas_mode   = 1'b1;
        end
        eawc_pkg::EAWC_IF_SDRAM: begin
          timing.first_wait  = {1'b0, code};
          timing.lat_illegal = code == 3'h0 || code > 3'h5 ||
                               (ras_down && (code == 3'h1 ||
                               code == 3'h4 || code == 3'h5));
        end
        default: begin
          timing.first_wait = eawc_pkg::wait_steps(code);
          timing.rdy_first  = code != 3'h0;
          timing.later_wait = brom_area0 ? {1'b0, pitch} : 4'h0;
          timing.rdy_later  = brom_area0 && pitch != 3'h0;
        end
      endcase
    end
  end

endmodule

// ===== rtl/eawc_ctrl.sv
module eawc_ctrl #(
  parameter int ADDR_W = 8
) (
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  input  wire logic [ADDR_W-1:0]    reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [31:0]          reg_rdata,
  input  wire logic                 acc_req,
  input  eawc_pkg::eawc_req_s       acc_info,
  input  wire logic                 ext_ready_n,
  output logic                      acc_busy,
  output logic                      beat_strobe,
  output logic                      acc_done,
  output logic                      cas_active,
  output logic                      rdy_sampled,
  output logic      [2:0]           cas_latency
);

  // ****************************************************************
  // Elaboration check.
  // ****************************************************************
  if (ADDR_W < 4 || ADDR_W > 8) begin : g_bad_addr
    $error("ADDR_W must lie between 4 and 8");
  end

  typedef enum logic {ST_IDLE, ST_WAIT} eawc_state_e;

  logic [31:0]            wait_ctrl_ff;
  logic [31:0]            if_cfg_ff;
  logic                   illegal_ff;
  logic [31:0]            rdata_ff;
  eawc_state_e            state_ff;
  logic [3:0]             cnt_ff;
  logic [2:0]             beats_left_ff;
  logic                   first_ff;
  eawc_pkg::eawc_timing_s cur_ff;
  logic                   beat_ff;
  logic                   done_ff;
  logic                   rdy_meta_ff;
  logic                   rdy_sync_ff;
  logic [2:0]             lat_ff;
  logic [2:0]             sel_code;
  logic [1:0]             sel_iface;
  logic                   take;
  logic                   rdy_en;
  logic                   go;
  logic                   st_wr;
  logic [7:0]             addr8;
  eawc_pkg::eawc_timing_s dec;

  // ****************************************************************
  // Register port.
  // ****************************************************************
  assign addr8 = 8'(reg_addr);
  assign st_wr = reg_wr && addr8 == eawc_pkg::OFS_STATUS;

  // Wait control word; reserved bit 12 is masked to read zero.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_ctrl_ff <= eawc_pkg::WAIT_CTRL_RST;
    end else if (reg_wr && addr8 == eawc_pkg::OFS_WAIT_CTRL) begin
      wait_ctrl_ff <= reg_wdata & eawc_pkg::WAIT_CTRL_MASK;
    end
  end

  // Interface type for areas 2 and 3 and the global mode bits.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      if_cfg_ff <= eawc_pkg::IF_CFG_RST;
    end else if (reg_wr && addr8 == eawc_pkg::OFS_IF_CFG) begin
      if_cfg_ff <= reg_wdata & eawc_pkg::IF_CFG_MASK;
    end
  end

  // Bad latency flag: a new event beats a write-one clear.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      illegal_ff <= 1'b0;
    end else if (take && dec.lat_illegal) begin
      illegal_ff <= 1'b1;
    end else if (st_wr && reg_wdata[eawc_pkg::ST_ILLEGAL_BIT]) begin
      illegal_ff <= 1'b0;
    end
  end

  // Read data stand one cycle after the strobe; unmapped reads give 0.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (addr8)
        eawc_pkg::OFS_WAIT_CTRL: rdata_ff <= wait_ctrl_ff;
        eawc_pkg::OFS_IF_CFG:    rdata_ff <= if_cfg_ff;
        eawc_pkg::OFS_STATUS: begin
          rdata_ff <= {24'h0000_00, cnt_ff, 2'h0, illegal_ff,
                       state_ff == ST_WAIT};
        end
        default:                 rdata_ff <= 32'h0000_0000;
      endcase
    end else begin
      rdata_ff <= 32'h0000_0000;
    end
  end
  assign reg_rdata = rdata_ff;

  // ****************************************************************
  // Ready-wait pin synchroniser.
  // ****************************************************************
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdy_meta_ff <= 1'b1;
      rdy_sync_ff <= 1'b1;
    end else begin
      rdy_meta_ff <= ext_ready_n;
      rdy_sync_ff <= rdy_meta_ff;
    end
  end

  // ****************************************************************
  // Field selection and decode at the start of an access.
  // ****************************************************************
  // Areas 0 and 1 have no dynamic-memory option.
  always_comb begin
    case (acc_info.area)
      2'h3: begin
        sel_code  = wait_ctrl_ff[eawc_pkg::AREA3_LSB +: 3];
        sel_iface = if_cfg_ff[eawc_pkg::A3_TYPE_LSB +: 2];
      end
      2'h2: begin
        sel_code  = wait_ctrl_ff[eawc_pkg::AREA2_LSB +: 3];
        sel_iface = if_cfg_ff[eawc_pkg::A2_TYPE_LSB +: 2];
      end
      2'h1: begin
        sel_code  = wait_ctrl_ff[eawc_pkg::AREA1_LSB +: 3];
        sel_iface = 2'h0;
      end
      default: begin
        sel_code  = wait_ctrl_ff[eawc_pkg::AREA0_LSB +: 3];
        sel_iface = 2'h0;
      end
    endcase
  end

  eawc_decode u_decode (
    .code       (sel_code),
    .pitch      (wait_ctrl_ff[eawc_pkg::BURST_LSB +: 3]),
    .iface      (sel_iface),
    .multiplexed_bus_interface        (if_cfg_ff[eawc_pkg::MPX_BIT]),
    .brom_area0 (if_cfg_ff[eawc_pkg::BROM_BIT] && acc_info.area == 2'h0),
    .is_write   (acc_info.write),
    .ras_down   (if_cfg_ff[eawc_pkg::RASD_BIT]),
    .timing     (dec)
  );

  // ****************************************************************
  // Access sequencer.
  // ****************************************************************
  // Ready-wait is watched only once the inserted waits have run out.
  assign take   = acc_req && state_ff == ST_IDLE;
  assign rdy_en = first_ff ? cur_ff.rdy_first : cur_ff.rdy_later;
  assign go     = state_ff == ST_WAIT && cnt_ff == 4'h0 &&
                  (!rdy_en || !rdy_sync_ff);

  // Latch the decoded timing so a register write mid-access is harmless.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_ff <= '0;
      lat_ff <= 3'h0;
    end else if (take) begin
      cur_ff <= dec;
      // Only a synchronous dynamic memory access records its latency;
      // the reserved type runs static timing and must leave it alone.
      if (!if_cfg_ff[eawc_pkg::MPX_BIT] &&
          sel_iface == 2'(eawc_pkg::EAWC_IF_SDRAM)) begin
        lat_ff <= sel_code;
      end
    end
  end

  // State, wait counter and beat bookkeeping.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff      <= ST_IDLE;
      cnt_ff        <= 4'h0;
      beats_left_ff <= 3'h0;
      first_ff      <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (take) begin
            state_ff      <= ST_WAIT;
            cnt_ff        <= dec.first_wait;
            beats_left_ff <= (acc_info.beats == 3'h0) ? 3'h1 :
                             acc_info.beats;
            first_ff      <= 1'b1;
          end
        end
        ST_WAIT: begin
          if (cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
          end else if (go) begin
            if (beats_left_ff > 3'h1 && !cur_ff.cas_mode) begin
              cnt_ff        <= cur_ff.later_wait;
              beats_left_ff <= beats_left_ff - 3'h1;
              first_ff      <= 1'b0;
            end else begin
              state_ff <= ST_IDLE;
            end
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Beat and completion pulses, one cycle after the decision.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      beat_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      beat_ff <= go;
      done_ff <= go && (beats_left_ff <= 3'h1 || cur_ff.cas_mode);
    end
  end

  assign acc_busy    = state_ff == ST_WAIT;
  assign beat_strobe = beat_ff;
  assign acc_done    = done_ff;
  assign cas_active  = state_ff == ST_WAIT && cur_ff.cas_mode;
  assign rdy_sampled = state_ff == ST_WAIT && cnt_ff == 4'h0 && rdy_en;
  assign cas_latency = lat_ff;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  logic std_if;
  assign std_if = !if_cfg_ff[eawc_pkg::MPX_BIT] && sel_iface == 2'h0;

  AST_AREA3_CODE7: assert property (
    take && acc_info.area == 2'h3 && std_if && sel_code == 3'h7
    |=> cnt_ff == 4'hF)
    else $error("area 3 code 7 did not load 15 waits");
  AST_AREA2_CODE5: assert property (
    take && acc_info.area == 2'h2 && std_if && sel_code == 3'h5
    |=> cnt_ff == 4'h9 && cur_ff.rdy_first)
    else $error("area 2 code 5 did not load 9 waits with ready");
  AST_AREA1_ZERO: assert property (
    take && acc_info.area == 2'h1 && std_if && sel_code == 3'h0
    |=> !rdy_sampled)
    else $error("area 1 code 0 sampled ready-wait");
  AST_AREA0_CODE4: assert property (
    take && acc_info.area == 2'h0 && std_if && sel_code == 3'h4
    |=> cnt_ff == 4'h6)
    else $error("area 0 code 4 did not load 6 waits");
  AST_CAS_WIDTH7: assert property (
    take && dec.cas_mode && sel_code == 3'h4
    |=> cas_active [*7] ##1 !cas_active)
    else $error("column strobe width for code 4 is not 7");
  AST_BAD_LATENCY: assert property (
    take && dec.lat_illegal
    |=> illegal_ff)
    else $error("illegal latency code not flagged");
  // Checks the decode itself: a dynamic area must never enable ready-wait.
  AST_DRAM_NO_RDY: assert property (
    take && !if_cfg_ff[eawc_pkg::MPX_BIT] &&
    (sel_iface == 2'h1 || sel_iface == 2'h2)
    |=> !cur_ff.rdy_first && !cur_ff.rdy_later)
    else $error("dynamic memory access enabled ready-wait");
  AST_BURST_PITCH: assert property (
    go && beats_left_ff > 3'h1 && !cur_ff.cas_mode
    |=> cnt_ff == $past(cur_ff.later_wait) && !first_ff)
    else $error("burst pitch not loaded before next beat");
  AST_MPX_READ0: assert property (
    take && if_cfg_ff[eawc_pkg::MPX_BIT] && !acc_info.write &&
    sel_code[1:0] == 2'h0 |=> cnt_ff == 4'h1)
    else $error("multiplexed read code 0 did not load one wait");
  AST_FIELD_POS: assert property (
    reg_wr && addr8 == eawc_pkg::OFS_WAIT_CTRL
    |=> wait_ctrl_ff[15:13] == $past(reg_wdata[15:13]))
    else $error("area 3 field not at bits 15 to 13");
  AST_COUNT_DOWN: assert property (
    acc_busy && cnt_ff != 4'h0
    |=> cnt_ff == $past(cnt_ff) - 4'h1 && !beat_strobe)
    else $error("wait counter did not step by one");

  COV_BURST: cover property (go && beats_left_ff > 3'h1 ##[1:20] acc_done);
  COV_DRAM: cover property (cas_active ##1 acc_done);
  COV_RDY_HOLD: cover property (rdy_sampled && rdy_sync_ff ##1 rdy_sampled);

endmodule

// ===== tb/eawc_mem_model.sv
module eawc_mem_model (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       stall,
  input  wire logic       beat_strobe,
  output logic            ext_ready_n,
  output logic      [7:0] beat_cnt
);
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************************************
  // Slow memory: the pin holds wait while the bench commands a stall.
  // ****************************************************************
  // Driven at all times, so the pin never floats between accesses.
  assign ext_ready_n = stall;

  // Beats taken by the memory, kept for debugging slow transfers.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      beat_cnt <= 8'h00;
    end else if (beat_strobe) begin
      beat_cnt <= beat_cnt + 8'h01;
    end
  end
endmodule

// ===== tb/test_external_area_wait_control.sv
module test_external_area_wait_control;
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************************************
  // Signals.
  // ****************************************************************
  logic                 core_clk    = 1'b0;
  logic                 sys_rst     = 1'b1;
  logic [7:0]           reg_addr    = 8'h00;
  logic [31:0]          reg_wdata   = 32'h0000_0000;
  logic                 reg_wr      = 1'b0;
  logic                 reg_rd      = 1'b0;
  logic [31:0]          reg_rdata;
  logic                 acc_req     = 1'b0;
  eawc_pkg::eawc_req_s  acc_info    = '0;
  logic                 stall       = 1'b0;
  logic                 ext_ready_n;
  logic                 acc_busy;
  logic                 beat_strobe;
  logic                 acc_done;
  logic                 cas_active;
  logic                 rdy_sampled;
  logic [2:0]           cas_latency;
  int                   mismatches  = 0;
  int                   comparisons = 0;
  int                   lat;
  int                   gap;
  int                   cas_cnt;
  int                   rdy_cnt;
  int                   lsb[4]      = '{3, 6, 9, 13};
  int                   steps[8]    = '{0, 1, 2, 3, 6, 9, 12, 15};
  int                   width[8]    = '{1, 2, 3, 4, 7, 10, 13, 16};

  // Clock at 10 MHz.
  always #50 core_clk = ~core_clk;

  eawc_ctrl #(.ADDR_W(8)) dut (
    .core_clk    (core_clk),
    .sys_rst     (sys_rst),
    .reg_addr    (reg_addr),
    .reg_wdata   (reg_wdata),
    .reg_wr      (reg_wr),
    .reg_rd      (reg_rd),
    .reg_rdata   (reg_rdata),
    .acc_req     (acc_req),
    .acc_info    (acc_info),
    .ext_ready_n (ext_ready_n),
    .acc_busy    (acc_busy),
    .beat_strobe (beat_strobe),
    .acc_done    (acc_done),
    .cas_active  (cas_active),
    .rdy_sampled (rdy_sampled),
    .cas_latency (cas_latency)
  );

  eawc_mem_model mem (
    .core_clk    (core_clk),
    .sys_rst     (sys_rst),
    .stall       (stall),
    .beat_strobe (beat_strobe),
    .ext_ready_n (ext_ready_n),
    .beat_cnt    ()
  );

  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // One access; rel is the cycle at which a stall is lifted.
  task automatic access(input logic [1:0] area, input logic w,
                        input logic [2:0] beats, input int rel);
    int n;
    n       = 0;
    lat     = 0;
    gap     = 0;
    cas_cnt = 0;
    rdy_cnt = 0;
    @(posedge core_clk);
    acc_req  <= 1'b1;
    acc_info <= '{area: area, write: w, beats: beats};
    @(posedge core_clk);
    acc_req <= 1'b0;
    // Busy and the column strobe already stand in the cycle after take.
    #1;
    chk(32'(acc_busy), 32'h0000_0001);
    if (cas_active === 1'b1) cas_cnt++;
    if (rdy_sampled === 1'b1) rdy_cnt++;
    while (n < 80) begin
      @(posedge core_clk);
      #1;
      n++;
      if (n == rel) stall <= 1'b0;
      if (cas_active === 1'b1) cas_cnt++;
      if (rdy_sampled === 1'b1) rdy_cnt++;
      if (beat_strobe === 1'b1) begin
        if (lat == 0) lat = n;
        else if (gap == 0) gap = n - lat;
      end
      if (acc_done === 1'b1) break;
    end
    if (n >= 80) chk(32'(n), 32'(0));
    chk(32'(acc_busy), 32'h0000_0000);
  endtask

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_regs();
    logic [31:0] d;
    rd(eawc_pkg::OFS_WAIT_CTRL, d);
    chk(d, 32'h0000_EFFF);
    wr(eawc_pkg::OFS_WAIT_CTRL, 32'hFFFF_FFFF);
    rd(eawc_pkg::OFS_WAIT_CTRL, d);
    chk(d, 32'h0000_EFFF);
    rd(8'h0C, d);
    chk(d, 32'h0000_0000);
    $display("test regs done");
  endtask

  // Every code of every area, ready held low.
  task automatic t_sram();
    for (int a = 0; a < 4; a++) begin
      for (int c = 0; c < 8; c++) begin
        wr(eawc_pkg::OFS_WAIT_CTRL, 32'(c) << lsb[a]);
        access(2'(a), 1'b0, 3'h1, 0);
        chk(32'(lat), 32'(steps[c] + 1));
      end
    end
    $display("test sram done");
  endtask

  // Code 0 ignores the stalled pin, code 1 waits for its release.
  task automatic t_ready();
    for (int a = 0; a < 4; a++) begin
      stall <= 1'b1;
      wr(eawc_pkg::OFS_WAIT_CTRL, 32'h0000_0000);
      repeat (3) @(posedge core_clk);
      access(2'(a), 1'b0, 3'h1, 8);
      chk(32'(lat), 32'(1));
      chk(32'(rdy_cnt), 32'(0));
      wr(eawc_pkg::OFS_WAIT_CTRL, 32'h1 << lsb[a]);
      access(2'(a), 1'b0, 3'h1, 8);
      chk(32'(lat > 8 && lat <= 14), 32'(1));
      chk(32'(rdy_cnt > 0), 32'(1));
      repeat (3) @(posedge core_clk);
    end
    $display("test ready done");
  endtask

  // Column strobe width, with the pin stalled throughout.
  task automatic t_dram();
    wr(eawc_pkg::OFS_IF_CFG, 32'h0000_0005);
    stall <= 1'b1;
    for (int a = 2; a < 4; a++) begin
      for (int c = 0; c < 8; c++) begin
        wr(eawc_pkg::OFS_WAIT_CTRL, 32'(c) << lsb[a]);
        access(2'(a), 1'b0, 3'h1, 70);
        chk(32'(cas_cnt), 32'(width[c]));
        chk(32'(rdy_cnt), 32'(0));
        chk(32'(lat < 70), 32'(1));
      end
    end
    $display("test dram done");
  endtask

  // Latency codes and the illegal flag, with and without row-down.
  task automatic t_sdram();
    logic [31:0] d;
    logic        ok;
    for (int m = 0; m < 2; m++) begin
      wr(eawc_pkg::OFS_IF_CFG, m ? 32'h0000_004A : 32'h0000_000A);
      for (int c = 0; c < 8; c++) begin
        ok = m ? (c == 2 || c == 3) : (c >= 1 && c <= 5);
        wr(eawc_pkg::OFS_STATUS, 32'h0000_0002);
        wr(eawc_pkg::OFS_WAIT_CTRL, 32'(c) << lsb[2 + (c % 2)]);
        access(2'(2 + (c % 2)), 1'b0, 3'h1, 70);
        chk(32'(cas_latency), 32'(c));
        chk(32'(lat < 70), 32'(1));
        rd(eawc_pkg::OFS_STATUS, d);
        chk(32'(d[1]), 32'(!ok));
      end
    end
    stall <= 1'b0;
    repeat (3) @(posedge core_clk);
    $display("test sdram done");
  endtask

  // Burst pitch adds exactly its code between later beats.
  task automatic t_brom();
    int g0;
    g0 = 0;
    wr(eawc_pkg::OFS_IF_CFG, 32'h0000_0020);
    for (int p = 0; p < 8; p++) begin
      wr(eawc_pkg::OFS_WAIT_CTRL, 32'(p));
      access(2'h0, 1'b0, 3'h2, 0);
      if (p == 0) g0 = gap;
      chk(32'(gap - g0), 32'(p));
    end
    $display("test brom done");
  endtask

  // Multiplexed bus: first-beat table, top bit for later beats.
  task automatic t_mpx();
    int rt[4] = '{1, 1, 2, 3};
    int g[2][4];
    wr(eawc_pkg::OFS_IF_CFG, 32'h0000_0010);
    for (int c = 0; c < 8; c++) begin
      for (int w = 0; w < 2; w++) begin
        wr(eawc_pkg::OFS_WAIT_CTRL, 32'(c) << lsb[1]);
        access(2'h1, w[0], 3'h2, 0);
        chk(32'(lat), 32'((w ? c % 4 : rt[c % 4]) + 1));
        if (c < 4) g[w][c] = gap;
        else chk(32'(gap - g[w][c - 4]), 32'(1));
      end
    end
    stall <= 1'b1;
    wr(eawc_pkg::OFS_WAIT_CTRL, 32'h0000_0000);
    access(2'h1, 1'b1, 3'h1, 8);
    chk(32'(lat > 8), 32'(1));
    $display("test mpx done");
  endtask

  // ****************************************************************
  // Run control.
  // ****************************************************************
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    t_regs();
    t_sram();
    t_ready();
    t_dram();
    t_sdram();
    t_brom();
    t_mpx();
    conclude();
  end

  // The run needs about a thousand cycles; this leaves ample margin.
  initial begin
    #(100 * 30000);
    mismatches++;
    conclude();
  end
endmodule
